/* File: src/snr_map.vh */
// constants for the serial nvm/rtc slave transaction block
`ifndef SNR_MAP_VH
`define SNR_MAP_VH
`define SNR_ID_ARRAY 4'ha
`define SNR_ID_CTRL 4'hd
`define SNR_SEL_BITS 3'h7
`define SNR_ARR_PAGE_MASK 16'h003f
`define SNR_CTL_PAGE_MASK 16'h0007
`define SNR_ARR_ADDR_MASK 16'h01ff
`define SNR_CTL_ADDR_MASK 16'h003f
`define SNR_ADDR_RST 16'h0000
`define SNR_STATUS_ADDR 16'h003f
`define SNR_WEL_BIT 1
`define SNR_WR_TIME_NS 5000000
`define SNR_CLK_NS 10
`define SNR_WR_CYCLES (`SNR_WR_TIME_NS / `SNR_CLK_NS)
`define SNR_FIFO_DEPTH 8
`endif

/* File: src/snr_fifo.v */
// small fifo for the write-data path
`timescale 1ns/100ps
module snr_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_i,
    input wire srst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;
    assign in_ready_o = (cnt_r != DEPTH[AW:0]);
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o = mem[rp_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    always @(posedge clk_i)
    begin
        if (push)
            mem[wp_r] <= in_data_i;
        if (srst_i)
        begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            if (push & ~pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // snr_fifo

/* File: src/snr_slave.v */
// two-wire slave transaction logic with nonvolatile write model
`timescale 1ns/100ps
`include "snr_map.vh"
module snr_slave #(
    parameter WR_CYCLES = `SNR_WR_CYCLES,
    parameter [7:0] PROT_LO = 8'h00,
    parameter [7:0] PROT_HI = 8'h00
) (
    input wire clk_i,
    input wire srst_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    output reg busy_o
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg [7:0] arr_mem [0:511];
    reg [7:0] ctl_mem [0:63];
    reg [7:0] page_buf [0:63];
    reg [63:0] page_vld_r;

    // ------------------------------------------------------------
    // bus condition detect
    // ------------------------------------------------------------
    reg scl_q_r;
    reg sda_q_r;
    wire start_det;
    wire stop_det;
    wire scl_rise;
    wire scl_fall;
    assign start_det = scl_i & scl_q_r & sda_q_r & ~sda_i;
    assign stop_det = scl_i & scl_q_r & ~sda_q_r & sda_i;
    assign scl_rise = scl_i & ~scl_q_r;
    assign scl_fall = ~scl_i & scl_q_r;

    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_DEV = 7'h02;
    localparam [6:0] S_ADH = 7'h04;
    localparam [6:0] S_ADL = 7'h08;
    localparam [6:0] S_WDAT = 7'h10;
    localparam [6:0] S_RDAT = 7'h20;
    localparam [6:0] S_ACK = 7'h40;

    reg [6:0] st_r;
    reg [6:0] after_ack_r;
    reg [3:0] bit_r;
    reg [7:0] sh_r;
    reg ctl_r;
    reg [15:0] addr_r;
    reg [15:0] base_r;
    reg [6:0] nbytes_r;
    reg ack_drv_r;
    reg out_bit_r;
    reg rd_drive_r;
    reg mst_ack_r;
    reg wel_r;
    reg stat_r;
    reg [31:0] wcnt_r;
    reg flush_r;
    reg [6:0] fl_idx_r;

    // wrap address inside current page
    function [15:0] page_inc;
        input [15:0] a;
        input c;
        reg [15:0] m;
        begin
            m = c ? `SNR_CTL_PAGE_MASK : `SNR_ARR_PAGE_MASK;
            page_inc = (a & ~m) | ((a + 16'h0001) & m);
        end
    endfunction

    function [15:0] space_inc;
        input [15:0] a;
        input c;
        begin
            space_inc = (a + 16'h0001) & (c ? `SNR_CTL_ADDR_MASK : `SNR_ARR_ADDR_MASK);
        end
    endfunction

    wire [7:0] rd_byte;
    assign rd_byte = ctl_r ? ctl_mem[addr_r[5:0]] : arr_mem[addr_r[8:0]];
    wire prot_hit;
    assign prot_hit = ~ctl_r && (addr_r[8:1] >= PROT_LO) && (addr_r[8:1] < PROT_HI);

    // released pin while busy: open drain pulls low only
    assign sda_o = 1'b0;
    assign sda_oe_o = ~busy_o & (ack_drv_r | (rd_drive_r & ~out_bit_r));

    // ------------------------------------------------------------
    // flush fifo: page buffer entries to nonvolatile store
    // ------------------------------------------------------------
    wire fin_valid;
    wire fin_ready;
    wire fout_valid;
    wire [24:0] fout_data;
    wire [6:0] fl_slot;
    assign fl_slot = fl_idx_r;
    assign fin_valid = flush_r & (fl_idx_r != 7'h40) & page_vld_r[fl_idx_r[5:0]];
    // drain waits for an idle engine, and the engine is held idle while busy, so the buffer never backs up
    wire drain_ok;
    assign drain_ok = (st_r == S_IDLE);

    snr_fifo #(.WIDTH(25), .DEPTH(`SNR_FIFO_DEPTH), .AW(3)) u_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(fin_valid),
        .in_ready_o(fin_ready),
        .in_data_i({ctl_r, (base_r | {10'h000, fl_slot[5:0]}), page_buf[fl_slot[5:0]]}),
        .out_valid_o(fout_valid),
        .out_ready_i(drain_ok),
        .out_data_o(fout_data)
    );

    always @(posedge clk_i)
    begin
        if (fout_valid & drain_ok)
        begin
            if (fout_data[24])
                ctl_mem[fout_data[13:8]] <= fout_data[7:0];
            else
                arr_mem[fout_data[16:8]] <= fout_data[7:0];
        end
    end

    // ------------------------------------------------------------
    // transaction engine
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        scl_q_r <= scl_i;
        sda_q_r <= sda_i;
        if (srst_i)
        begin
            st_r <= S_IDLE;
            after_ack_r <= S_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ctl_r <= 1'b0;
            addr_r <= `SNR_ADDR_RST;
            base_r <= 16'h0000;
            nbytes_r <= 7'h00;
            ack_drv_r <= 1'b0;
            out_bit_r <= 1'b1;
            rd_drive_r <= 1'b0;
            mst_ack_r <= 1'b0;
            wel_r <= 1'b0;
            stat_r <= 1'b0;
            busy_o <= 1'b0;
            wcnt_r <= 32'h0;
            flush_r <= 1'b0;
            fl_idx_r <= 7'h00;
            page_vld_r <= 64'h0;
        end
        else if (busy_o)
        begin
            // bus ignored until the cycle and its flush both complete
            if (flush_r)
            begin
                if (fl_idx_r == 7'h40)
                    flush_r <= 1'b0;
                else if (~page_vld_r[fl_idx_r[5:0]] | fin_ready)
                    fl_idx_r <= fl_idx_r + 7'h01;
            end
            if (wcnt_r != 32'h0)
                wcnt_r <= wcnt_r - 32'h1;
            else if (~flush_r & ~fout_valid)
            begin
                busy_o <= 1'b0;
                page_vld_r <= 64'h0;
            end
            st_r <= S_IDLE;
            ack_drv_r <= 1'b0;
            rd_drive_r <= 1'b0;
        end
        else if (start_det)
        begin
            st_r <= S_DEV;
            bit_r <= 4'h0;
            ack_drv_r <= 1'b0;
            rd_drive_r <= 1'b0;
            nbytes_r <= 7'h00;
        end
        else if (stop_det)
        begin
            ack_drv_r <= 1'b0;
            rd_drive_r <= 1'b0;
            st_r <= S_IDLE;
            // the stop's own scl rise has already counted one bit
            if ((nbytes_r != 7'h00) && (st_r == S_WDAT) && (bit_r <= 4'h1) && !prot_hit)
            begin
                busy_o <= 1'b1;
                wcnt_r <= WR_CYCLES;
                flush_r <= 1'b1;
                fl_idx_r <= 7'h00;
            end
            else
                page_vld_r <= 64'h0;
        end
        else if (scl_rise && (st_r != S_IDLE) && (st_r != S_ACK) && (st_r != S_RDAT))
        begin
            sh_r <= {sh_r[6:0], sda_i};
            bit_r <= bit_r + 4'h1;
        end
        else if (scl_rise && (st_r == S_ACK))
            mst_ack_r <= ~sda_i;
        else if (scl_fall && (st_r != S_IDLE))
        begin
            if (st_r == S_ACK)
            begin
                ack_drv_r <= 1'b0;
                bit_r <= 4'h0;
                st_r <= after_ack_r;
                if (after_ack_r == S_RDAT)
                begin
                    if (rd_drive_r & ~mst_ack_r)
                    begin
                        st_r <= S_IDLE;
                        rd_drive_r <= 1'b0;
                    end
                    else
                    begin
                        sh_r <= rd_byte;
                        out_bit_r <= rd_byte[7];
                        rd_drive_r <= 1'b1;
                        addr_r <= space_inc(addr_r, ctl_r);
                    end
                end
            end
            else if (st_r == S_RDAT)
            begin
                if (bit_r == 4'h7)
                begin
                    st_r <= S_ACK;
                    after_ack_r <= S_RDAT;
                    out_bit_r <= 1'b1;
                end
                else
                begin
                    sh_r <= {sh_r[6:0], 1'b1};
                    out_bit_r <= sh_r[6];
                    bit_r <= bit_r + 4'h1;
                end
            end
            else if (bit_r == 4'h8)
            begin
                st_r <= S_ACK;
                case (st_r)
                    S_DEV:
                    begin
                        if ((sh_r[7:4] == `SNR_ID_ARRAY || sh_r[7:4] == `SNR_ID_CTRL)
                            && sh_r[3:1] == `SNR_SEL_BITS)
                        begin
                            ack_drv_r <= 1'b1;
                            ctl_r <= (sh_r[7:4] == `SNR_ID_CTRL);
                            after_ack_r <= sh_r[0] ? S_RDAT : S_ADH;
                            rd_drive_r <= 1'b0;
                        end
                        else
                            st_r <= S_IDLE;
                    end
                    S_ADH:
                    begin
                        ack_drv_r <= 1'b1;
                        addr_r[15:8] <= sh_r;
                        after_ack_r <= S_ADL;
                    end
                    S_ADL:
                    begin
                        ack_drv_r <= 1'b1;
                        addr_r[7:0] <= sh_r;
                        stat_r <= ctl_r & ({addr_r[15:8], sh_r} == `SNR_STATUS_ADDR);
                        base_r <= {addr_r[15:8], sh_r} & ~(ctl_r ? `SNR_CTL_PAGE_MASK :
                            `SNR_ARR_PAGE_MASK);
                        after_ack_r <= S_WDAT;
                    end
                    default:
                    begin
                        // status write limited to one byte
                        // address moves on after one byte, so a flag remembers status
                        if ((ctl_r & ~wel_r & ~stat_r) || (stat_r & (nbytes_r != 7'h00)))
                            ack_drv_r <= 1'b0;
                        else
                        begin
                            ack_drv_r <= 1'b1;
                            if (stat_r)
                                wel_r <= sh_r[`SNR_WEL_BIT];
                            page_buf[addr_r[5:0] & (ctl_r ? 6'h07 : 6'h3f)] <= sh_r;
                            page_vld_r[addr_r[5:0] & (ctl_r ? 6'h07 : 6'h3f)] <= 1'b1;
                            addr_r <= page_inc(addr_r, ctl_r);
                            nbytes_r <= nbytes_r + 7'h01;
                        end
                        after_ack_r <= S_WDAT;
                    end
                endcase
            end
        end
    end
endmodule // snr_slave

/* File: dv/snr_bus_master.sv */
// two-wire bus master model for the slave bench
`timescale 1ns/100ps
module snr_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // sda_o high means released; the pull-up then reads 1
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // phases of 1-4 clk keep the slave's synchronous sampling safe
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        r = sda_i;
        scl_o <= 1'b0;
        tick(1);
    endtask
    task automatic start();
        sda_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(4);
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, r);
    endtask
endmodule // snr_bus_master

/* File: dv/snr_slave_properties.sv */
// concurrent checks on the slave's bus pins and busy flag
`timescale 1ns/100ps
module snr_slave_properties #(
    parameter WR_CYCLES = 50
) (
    input wire clk_i,
    input wire srst_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [31:0] busy_cnt_r;
    always_ff @(posedge clk_i)
        busy_cnt_r <= (srst_i || !busy_o) ? 32'h0 : busy_cnt_r + 32'h1;
    sequence s_stop_seen; scl_i && $past(scl_i); endsequence
    sequence s_busy_drop; ##[1:1000] !busy_o; endsequence
    sequence s_hold3; sda_oe_o [*3]; endsequence
    property p_busy_quiet; busy_o |-> !sda_oe_o; endproperty
    property p_busy_start; $rose(busy_o) |-> s_stop_seen; endproperty
    property p_busy_end; $rose(busy_o) |-> s_busy_drop; endproperty
    property p_busy_len; $fell(busy_o) |-> busy_cnt_r >= WR_CYCLES - 1; endproperty
    property p_oe_change; $changed(sda_oe_o) |-> !scl_i; endproperty
    property p_ack_hold; $rose(scl_i) && sda_oe_o |-> s_hold3; endproperty
    property p_rst_clear;
        @(posedge clk_i) disable iff (1'b0) srst_i |=> !busy_o && !sda_oe_o;
    endproperty
    property p_od_low; sda_o == 1'b0; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("slave drives while busy");
    a_busy_start: assert property (p_busy_start) else $error("busy not after stop");
    a_busy_end: assert property (p_busy_end) else $error("busy never ends");
    a_busy_len: assert property (p_busy_len) else $error("busy too short");
    a_oe_change: assert property (p_oe_change) else $error("drive change, scl high");
    a_ack_hold: assert property (p_ack_hold) else $error("drive dropped, scl high");
    a_rst_clear: assert property (p_rst_clear) else $error("reset left state");
    a_od_low: assert property (p_od_low) else $error("data output not low");
endmodule // snr_slave_properties
bind snr_slave snr_slave_properties #(.WR_CYCLES(WR_CYCLES)) u_props (.clk_i(clk_i),
    .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .busy_o(busy_o));

/* File: dv/tb.sv */
// self-checking bench for the two-wire slave
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic scl;
    logic sda_m;
    wire sda_w;
    wire sda_o;
    wire sda_oe;
    wire busy;
    int errors = 0;
    int checks = 0;
    logic [7:0] mem [0:511];
    logic ack;
    logic [7:0] d;
    // pull-up: the line is low only where someone pulls it
    assign sda_w = sda_m & !sda_oe;
    snr_slave #(.WR_CYCLES(50), .PROT_LO(8'hc0), .PROT_HI(8'hcf)) uut (.clk_i(clk_i),
        .srst_i(srst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .busy_o(busy));
    snr_bus_master mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic head(input logic [7:0] sb, input logic [15:0] a);
        mst.start();
        mst.wr_byte(sb, ack);
        chk("slave ack", ack, 1);
        mst.wr_byte(a[15:8], ack);
        chk("addr hi ack", ack, 1);
        mst.wr_byte(a[7:0], ack);
        chk("addr lo ack", ack, 1);
    endtask
    // mode 0 expects a running write cycle, 1 an idle device, 2 either
    task automatic poll(input int mode);
        int n;
        n = 0;
        ack = 1'b0;
        while (!ack && n < 60)
        begin
            mst.start();
            mst.wr_byte(8'hae, ack);
            mst.stop();
            if (n == 0 && mode < 2)
                chk("first poll ack", ack, mode);
            n++;
        end
        chk("poll done", ack, 1);
    endtask
    task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0, input int mode);
        head(8'hae, a);
        for (int i = 0; i < n; i++)
        begin
            mst.wr_byte(d0 + i, ack);
            chk("data ack", ack, 1);
            if (mode == 0)
                mem[(a & 16'h1c0) | ((a + i) & 16'h3f)] = d0 + i;
        end
        mst.stop();
        chk("busy after stop", busy, mode == 0);
        poll(mode);
    endtask
    task automatic rd(input logic [15:0] a, input int n);
        head(8'hae, a);
        mst.start();
        mst.wr_byte(8'haf, ack);
        chk("read ack", ack, 1);
        for (int i = 0; i < n; i++)
        begin
            mst.rd_byte(i < n - 1, d);
            chk("read data", d, mem[(a + i) % 512]);
        end
        mst.stop();
    endtask
    task automatic cur(input int a);
        mst.start();
        mst.wr_byte(8'haf, ack);
        chk("current ack", ack, 1);
        mst.rd_byte(1'b0, d);
        chk("current data", d, mem[a]);
        mst.stop();
    endtask
    task automatic crd(input logic [15:0] a, input logic [7:0] e);
        head(8'hde, a);
        mst.start();
        mst.wr_byte(8'hdf, ack);
        chk("ctl read ack", ack, 1);
        mst.rd_byte(1'b0, d);
        chk("ctl read data", d, e);
        mst.stop();
    endtask
    task automatic t_pages();
        wr(16'h01ff, 1, 8'h11, 0);
        wr(16'h0000, 2, 8'h21, 0);
        wr(16'h0068, 70, 8'h40, 0);
        rd(16'h0040, 64);
        rd(16'h01ff, 3);
    endtask
    task automatic t_addr();
        head(8'hae, 16'h01ff);
        mst.stop();
        chk("no write", busy, 0);
        cur(16'h01ff);
        cur(0);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        cur(0);
    endtask
    task automatic t_abort();
        logic r;
        head(8'hae, 16'h0000);
        mst.wr_byte(8'h5a, ack);
        chk("abort data ack", ack, 1);
        for (int i = 0; i < 4; i++) mst.bit_io(1'b0, r);
        mst.stop();
        chk("abort busy", busy, 0);
        rd(16'h0000, 2);
    endtask
    task automatic t_guard();
        wr(16'h0184, 1, 8'h99, 1);
        head(8'hde, 16'h0010);
        mst.wr_byte(8'h5a, ack);
        chk("latch clear nack", ack, 0);
        mst.stop();
        head(8'hde, 16'h003f);
        mst.wr_byte(8'h02, ack);
        chk("status ack", ack, 1);
        mst.wr_byte(8'h06, ack);
        chk("second status nack", ack, 0);
        mst.stop();
        poll(2);
        crd(16'h003f, 8'h02);
        head(8'hde, 16'h0017);
        mst.wr_byte(8'h31, ack);
        chk("ctl data ack", ack, 1);
        mst.wr_byte(8'h32, ack);
        chk("ctl wrap ack", ack, 1);
        mst.stop();
        chk("ctl busy", busy, 1);
        poll(0);
        crd(16'h0017, 8'h31);
        crd(16'h0010, 8'h32);
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_i);
        errors++;
        finish_test();
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_pages();
        t_addr();
        t_abort();
        t_guard();
        finish_test();
    end
endmodule // tb
